//--- rtl/mts_timer_top.v
// Timer subsystem: real-time counter, general timers, auxiliary timers, radio timer, watchdogs.
`timescale 1ns/1ps
`include "mts_defines.vh"
module mts_timer_top (
	// Clock and reset
	input wire core_clk,
	input wire rstn,
	// System state
	input wire [1:0] power_mode,
	input wire dbg_halt,
	// Real-time counter
	input wire rtc_en,
	input wire rtc_dbg_run,
	input wire [31:0] rtc_inc,
	input wire rtc_cal_en,
	input wire [15:0] rtc_cal,
	input wire [2:0] rtc_ch_en,
	input wire [31:0] rtc_cmp,
	input wire [1:0] rtc_cap_evt,
	output reg [69:0] rtc_value_q,
	output reg rtc_cmp_evt_q,
	output reg [31:0] rtc_cap1_q,
	output reg [31:0] rtc_cap2_q,
	// General timer units
	input wire [3:0] gpt_split,
	input wire [7:0] gpt_en,
	input wire [23:0] gpt_mode,
	input wire [127:0] gpt_load,
	input wire [127:0] gpt_match,
	input wire [7:0] gpt_evt_in,
	output wire [127:0] gpt_value,
	output wire [7:0] gpt_evt_out,
	output wire [7:0] gpt_pwm,
	// Auxiliary timers 0 and 1
	input wire [1:0] aux_en,
	input wire [1:0] aux_periodic,
	input wire [1:0] aux_src_edge,
	input wire [7:0] aux_pre,
	input wire [31:0] aux_target,
	input wire [1:0] aux_tick_in,
	output wire [31:0] aux_value,
	output wire [1:0] aux_evt,
	// Auxiliary timer 2
	input wire aux2_en,
	input wire [1:0] aux2_clk_sel,
	input wire [15:0] aux2_period,
	input wire [3:0] aux2_ch_en,
	input wire [3:0] aux2_ch_cap,
	input wire [3:0] aux2_ch_periodic,
	input wire [63:0] aux2_cmp,
	input wire [3:0] aux2_cap_in,
	output reg [15:0] aux2_value_q,
	output wire [63:0] aux2_ch_val,
	output wire [3:0] aux2_evt,
	output wire [3:0] aux2_pwm,
	// Radio timer
	input wire radio_on,
	output reg [31:0] radio_time_q,
	// Watchdog
	input wire wdt_start,
	input wire wdt_kick,
	input wire [31:0] wdt_load,
	input wire wdt_irq_clr,
	output reg wdt_irq_q,
	output reg wdt_rst_q,
	// Always-on watchdog
	input wire aon_start,
	input wire aon_kick,
	input wire [31:0] aon_timeout,
	input wire aon_dbg_pause,
	output reg aon_rst_q
);
	reg [1:0] rs_q;
	wire rst_n = rs_q[1];
	wire [`MTS_NUM_TK-1:0] tk;
	wire [23:0] inc_tab [0:`MTS_NUM_TK-1];

	// Phase increment that makes a tick of the given rate out of the core clock.
	function [23:0] inc_of;
		input [63:0] hz;
		reg [63:0] t;
		begin
			t = (hz * `MTS_ACC_ONE) / `MTS_CORE_HZ;
			inc_of = t[23:0];
		end
	endfunction

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rs_q <= 2'h0;
		end else begin
			rs_q <= {rs_q[0], 1'b1};
		end
	end

	assign inc_tab[`MTS_TK_48M] = inc_of(`MTS_HZ_48M);
	assign inc_tab[`MTS_TK_24M] = inc_of(`MTS_HZ_24M);
	assign inc_tab[`MTS_TK_2M] = inc_of(`MTS_HZ_2M);
	assign inc_tab[`MTS_TK_4M] = inc_of(`MTS_HZ_4M);
	assign inc_tab[`MTS_TK_1M5] = inc_of(`MTS_HZ_1M5);
	assign inc_tab[`MTS_TK_LF] = inc_of(`MTS_HZ_LF);

	// Fractional dividers: average rate is slightly low from the truncated increment, single ticks jitter by one core cycle.
	genvar g;
	generate
		for (g = 0; g < `MTS_NUM_TK; g = g + 1) begin : g_div
			reg [23:0] acc_q;
			reg tk_q;
			wire [24:0] sum = {1'b0, acc_q} + {1'b0, inc_tab[g]};
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					acc_q <= 24'h0;
					tk_q <= 1'b0;
				end else begin
					acc_q <= sum[23:0];
					tk_q <= sum[24];
				end
			end
			assign tk[g] = tk_q;
		end
	endgenerate

	wire pm_up = (power_mode == `MTS_PM_ACTIVE) || (power_mode == `MTS_PM_IDLE);
	wire pm_aon = (power_mode != `MTS_PM_SHUTDOWN);

	// Real-time counter.
	wire rtc_run = rtc_en && pm_aon && (!dbg_halt || rtc_dbg_run) && tk[`MTS_TK_LF];
	wire [31:0] cal_ext = rtc_cal_en ? {{16{rtc_cal[15]}}, rtc_cal} : 32'h0;
	wire [31:0] rtc_step = rtc_inc + cal_ext;
	wire [69:0] rtc_nxt = rtc_value_q + {38'h0, rtc_step};
	wire [31:0] rtc_sl = rtc_value_q[`MTS_RTC_SL_HI:`MTS_RTC_SL_LO];
	wire [31:0] rtc_nsl = rtc_nxt[`MTS_RTC_SL_HI:`MTS_RTC_SL_LO];

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rtc_value_q <= 70'h0;
			rtc_cmp_evt_q <= 1'b0;
			rtc_cap1_q <= 32'h0;
			rtc_cap2_q <= 32'h0;
		end else begin
			rtc_cmp_evt_q <= 1'b0;
			if (rtc_run) begin
				rtc_value_q <= rtc_nxt;
				rtc_cmp_evt_q <= rtc_ch_en[0] && rtc_nsl == rtc_cmp && rtc_sl != rtc_cmp;
			end
			if (pm_aon && rtc_ch_en[1] && rtc_cap_evt[0]) begin
				rtc_cap1_q <= rtc_sl;
			end
			if (pm_aon && rtc_ch_en[2] && rtc_cap_evt[1]) begin
				rtc_cap2_q <= rtc_sl;
			end
		end
	end

	// General timer units, gated off outside active and idle.
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_gtu
			mts_gtu u_gtu (
				.clk(core_clk),
				.rst_n(rst_n),
				.tick(tk[`MTS_TK_48M]),
				.run(pm_up),
				.split(gpt_split[g]),
				.en(gpt_en[2*g+:2]),
				.mode(gpt_mode[6*g+:6]),
				.load(gpt_load[32*g+:32]),
				.match(gpt_match[32*g+:32]),
				.edge_in(gpt_evt_in[2*g+:2]),
				.value_q(gpt_value[32*g+:32]),
				.evt_q(gpt_evt_out[2*g+:2]),
				.pwm_q(gpt_pwm[2*g+:2])
			);
		end
	endgenerate

	// Auxiliary timers 0 and 1 count up to their target.
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_aux
			reg [15:0] cnt_q;
			reg [15:0] pre_q;
			reg run_q;
			reg en_q;
			reg src_q;
			reg evt_q;
			wire [15:0] pmask = ~(16'hffff << aux_pre[4*g+:4]);
			wire src_tk = aux_src_edge[g] ? (aux_tick_in[g] & ~src_q) : tk[`MTS_TK_24M];
			wire pre_tk = (pre_q & pmask) == pmask;
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					cnt_q <= 16'h0;
					pre_q <= 16'h0;
					run_q <= 1'b0;
					en_q <= 1'b0;
					src_q <= 1'b0;
					evt_q <= 1'b0;
				end else begin
					en_q <= aux_en[g];
					src_q <= aux_tick_in[g];
					evt_q <= 1'b0;
					if (aux_en[g] && !en_q) begin
						run_q <= 1'b1;
						cnt_q <= 16'h0;
						pre_q <= 16'h0;
					end else if (!aux_en[g]) begin
						run_q <= 1'b0;
					end else if (run_q && pm_aon && src_tk) begin
						pre_q <= pre_q + 16'h1;
						if (pre_tk && cnt_q == aux_target[16*g+:16]) begin
							evt_q <= 1'b1;
							cnt_q <= 16'h0;
							run_q <= aux_periodic[g];
						end else if (pre_tk) begin
							cnt_q <= cnt_q + 16'h1;
						end
					end
				end
			end
			assign aux_value[16*g+:16] = cnt_q;
			assign aux_evt[g] = evt_q;
		end
	endgenerate

	// Auxiliary timer 2 wraps at its period on the selected clock.
	reg a2_tk;
	always @* begin
		case (aux2_clk_sel)
			`MTS_A2_SEL_24M: a2_tk = tk[`MTS_TK_24M];
			`MTS_A2_SEL_2M: a2_tk = tk[`MTS_TK_2M];
			`MTS_A2_SEL_LF: a2_tk = tk[`MTS_TK_LF];
			default: a2_tk = 1'b0;
		endcase
	end
	wire a2_run = aux2_en && pm_aon && a2_tk;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aux2_value_q <= 16'h0;
		end else if (!aux2_en) begin
			aux2_value_q <= 16'h0;
		end else if (a2_run) begin
			aux2_value_q <= (aux2_value_q == aux2_period) ? 16'h0 : aux2_value_q + 16'h1;
		end
	end

	generate
		for (g = 0; g < 4; g = g + 1) begin : g_a2ch
			reg [15:0] val_q;
			reg armed_q;
			reg cen_q;
			reg cin_q;
			reg evt_q;
			reg pwm_q;
			wire [15:0] cmp = aux2_cmp[16*g+:16];
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					val_q <= 16'h0;
					armed_q <= 1'b0;
					cen_q <= 1'b0;
					cin_q <= 1'b0;
					evt_q <= 1'b0;
					pwm_q <= 1'b0;
				end else begin
					cen_q <= aux2_ch_en[g];
					cin_q <= aux2_cap_in[g];
					evt_q <= 1'b0;
					pwm_q <= aux2_en && aux2_ch_en[g] && !aux2_ch_cap[g] && aux2_value_q < cmp;
					if (aux2_ch_en[g] && !cen_q) begin
						armed_q <= 1'b1;
					end else if (!aux2_ch_en[g]) begin
						armed_q <= 1'b0;
					end else if (aux2_ch_cap[g]) begin
						if (armed_q && aux2_en && pm_aon && aux2_cap_in[g] && !cin_q) begin
							val_q <= aux2_value_q;
							evt_q <= 1'b1;
							armed_q <= aux2_ch_periodic[g];
						end
					end else if (armed_q && a2_run && aux2_value_q == cmp) begin
						evt_q <= 1'b1;
						armed_q <= aux2_ch_periodic[g];
					end
				end
			end
			assign aux2_ch_val[16*g+:16] = val_q;
			assign aux2_evt[g] = evt_q;
			assign aux2_pwm[g] = pwm_q;
		end
	endgenerate

	// Radio timer.
	reg radio_q;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			radio_q <= 1'b0;
			radio_time_q <= 32'h0;
		end else begin
			radio_q <= radio_on;
			if (radio_on != radio_q) begin
				radio_time_q <= rtc_value_q[`MTS_RAT_HI:`MTS_RAT_LO];
			end else if (radio_on && pm_up && tk[`MTS_TK_4M]) begin
				radio_time_q <= radio_time_q + 32'h1;
			end
		end
	end

	// Watchdog: first expiry raises the interrupt, an expiry with it still pending resets.
	reg wdt_on_q;
	reg [31:0] wdt_cnt_q;
	wire wdt_tk = wdt_on_q && pm_aon && !dbg_halt && tk[`MTS_TK_1M5];
	wire wdt_exp = wdt_tk && wdt_cnt_q == 32'h0;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdt_on_q <= 1'b0;
			wdt_cnt_q <= 32'h0;
			wdt_irq_q <= 1'b0;
			wdt_rst_q <= 1'b0;
		end else begin
			wdt_rst_q <= wdt_exp && wdt_irq_q;
			if (wdt_exp) begin
				wdt_irq_q <= 1'b1;
			end else if (wdt_irq_clr) begin
				wdt_irq_q <= 1'b0;
			end
			if (wdt_start && !wdt_on_q) begin
				wdt_on_q <= 1'b1;
				wdt_cnt_q <= wdt_load;
			end else if (wdt_on_q && wdt_kick) begin
				wdt_cnt_q <= wdt_load;
			end else if (wdt_exp) begin
				wdt_cnt_q <= wdt_load;
			end else if (wdt_tk) begin
				wdt_cnt_q <= wdt_cnt_q - 32'h1;
			end
		end
	end

	// Always-on watchdog; only the reset clears its running flag.
	reg aon_on_q;
	reg [31:0] aon_cnt_q;
	wire aon_tk = aon_on_q && pm_aon && !(dbg_halt && aon_dbg_pause) && tk[`MTS_TK_LF];
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aon_on_q <= 1'b0;
			aon_cnt_q <= 32'h0;
			aon_rst_q <= 1'b0;
		end else begin
			aon_rst_q <= 1'b0;
			if (aon_start && !aon_on_q) begin
				aon_on_q <= 1'b1;
				aon_cnt_q <= aon_timeout;
			end else if (aon_on_q && aon_kick) begin
				aon_cnt_q <= aon_timeout;
			end else if (aon_tk && aon_cnt_q <= 32'h1) begin
				aon_rst_q <= 1'b1;
				aon_cnt_q <= aon_timeout;
			end else if (aon_tk) begin
				aon_cnt_q <= aon_cnt_q - 32'h1;
			end
		end
	end
endmodule // mts_timer_top

//--- rtl/mts_defines.vh
// Shared constants for the timer subsystem.
`ifndef MTS_DEFINES_VH
`define MTS_DEFINES_VH
// Core clock and derived rates in Hz: 125 MHz, 48 MHz, 24 MHz, 2 MHz, 4 MHz, 1.5 MHz, 32768 Hz.
`define MTS_CORE_HZ 64'h7735940
`define MTS_HZ_48M 64'h2dc6c00
`define MTS_HZ_24M 64'h16e3600
`define MTS_HZ_2M 64'h1e8480
`define MTS_HZ_4M 64'h3d0900
`define MTS_HZ_1M5 64'h16e360
`define MTS_HZ_LF 64'h8000
// Phase accumulator scale, two to the 24th.
`define MTS_ACC_ONE 64'h1000000
`define MTS_NUM_TK 6
`define MTS_TK_48M 0
`define MTS_TK_24M 1
`define MTS_TK_2M 2
`define MTS_TK_4M 3
`define MTS_TK_1M5 4
`define MTS_TK_LF 5
// Power modes.
`define MTS_PM_ACTIVE 2'h0
`define MTS_PM_IDLE 2'h1
`define MTS_PM_STANDBY 2'h2
`define MTS_PM_SHUTDOWN 2'h3
// Real-time counter: 38 fraction bits; the compare and capture slice has 2^-16 s weight.
`define MTS_RTC_W 70
`define MTS_RTC_SL_HI 53
`define MTS_RTC_SL_LO 22
`define MTS_RAT_HI 47
`define MTS_RAT_LO 16
// General timer modes.
`define MTS_GM_ONESHOT 3'h0
`define MTS_GM_PERIODIC 3'h1
`define MTS_GM_PWM 3'h2
`define MTS_GM_EDGE_TIME 3'h3
`define MTS_GM_EDGE_CNT 3'h4
// Auxiliary timer 2 clock selection.
`define MTS_A2_SEL_24M 2'h0
`define MTS_A2_SEL_2M 2'h1
`define MTS_A2_SEL_LF 2'h2
`endif

//--- rtl/mts_gtu.v
// One general timer unit: one 32-bit timer or two 16-bit halves.
`timescale 1ns/1ps
`include "mts_defines.vh"
module mts_gtu (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Control
	input wire tick,
	input wire run,
	input wire split,
	input wire [1:0] en,
	input wire [5:0] mode,
	input wire [31:0] load,
	input wire [31:0] match,
	input wire [1:0] edge_in,
	// Results
	output reg [31:0] value_q,
	output reg [1:0] evt_q,
	output reg [1:0] pwm_q
);
	localparam [31:0] MASK16 = 32'h0000ffff;
	localparam [31:0] MASK32 = 32'hffffffff;
	reg [31:0] cnt_q;
	reg [1:0] en_q;
	reg [1:0] edge_q;

	// Returns the event flag over the next count for one timer of any width.
	function [32:0] step;
		input [31:0] c;
		input [31:0] ld;
		input [31:0] mt;
		input [2:0] md;
		input tk;
		input eg;
		input [31:0] msk;
		reg [31:0] n;
		reg e;
		begin
			n = c;
			e = 1'b0;
			case (md)
				`MTS_GM_ONESHOT: if (tk && c != 32'h0) begin
					n = c - 32'h1;
					e = (c == 32'h1);
				end
				`MTS_GM_PERIODIC, `MTS_GM_PWM: if (tk) begin
					n = (c == 32'h0) ? ld : c - 32'h1;
					e = (c == 32'h0);
				end
				`MTS_GM_EDGE_TIME: if (eg) begin
					n = 32'h0;
					e = 1'b1;
				end else if (tk) begin
					n = (c + 32'h1) & msk;
				end
				`MTS_GM_EDGE_CNT: if (eg) begin
					n = (c + 32'h1) & msk;
					e = (((c + 32'h1) & msk) == mt);
				end
				default: n = c;
			endcase
			step = {e, n & msk};
		end
	endfunction

	// Edge modes start from zero, the others from the load value.
	function [31:0] start;
		input [2:0] md;
		input [31:0] ld;
		begin
			start = (md == `MTS_GM_EDGE_TIME || md == `MTS_GM_EDGE_CNT) ? 32'h0 : ld;
		end
	endfunction

	wire [1:0] rise = edge_in & ~edge_q;
	wire [1:0] arm = en & ~en_q;
	wire [1:0] act = {split & en[1], en[0]} & {2{run}};
	wire [31:0] msk_lo = split ? MASK16 : MASK32;
	wire [31:0] c_lo = cnt_q & msk_lo;
	wire [31:0] c_hi = {16'h0, cnt_q[31:16]};
	wire [32:0] s_lo = step(c_lo, load & msk_lo, match & msk_lo, mode[2:0], tick, rise[0], msk_lo);
	wire [32:0] s_hi = step(c_hi, {16'h0, load[31:16]}, {16'h0, match[31:16]}, mode[5:3],
		tick, rise[1], MASK16);
	wire [31:0] n_lo = arm[0] ? start(mode[2:0], load & msk_lo) : (act[0] ? s_lo[31:0] : c_lo);
	wire [31:0] n_hi = arm[1] ? start(mode[5:3], {16'h0, load[31:16]}) :
		(act[1] ? s_hi[31:0] : c_hi);
	wire [31:0] n_all = split ? {n_hi[15:0], n_lo[15:0]} : n_lo;
	wire cap_lo = act[0] && rise[0] && mode[2:0] == `MTS_GM_EDGE_TIME;
	wire cap_hi = act[1] && rise[1] && mode[5:3] == `MTS_GM_EDGE_TIME;
	wire hold_lo = mode[2:0] == `MTS_GM_EDGE_TIME;
	wire hold_hi = mode[5:3] == `MTS_GM_EDGE_TIME;
	wire [31:0] v_lo = cap_lo ? c_lo : (hold_lo ? value_q & msk_lo : n_lo);
	wire [31:0] v_hi = cap_hi ? c_hi : (hold_hi ? {16'h0, value_q[31:16]} : n_hi);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 32'h0;
			value_q <= 32'h0;
			en_q <= 2'h0;
			edge_q <= 2'h0;
			evt_q <= 2'h0;
			pwm_q <= 2'h0;
		end else begin
			en_q <= en;
			edge_q <= edge_in;
			cnt_q <= n_all;
			value_q <= split ? {v_hi[15:0], v_lo[15:0]} : v_lo;
			evt_q <= act & {s_hi[32], s_lo[32]};
			pwm_q[0] <= act[0] && mode[2:0] == `MTS_GM_PWM && c_lo < (match & msk_lo);
			pwm_q[1] <= act[1] && mode[5:3] == `MTS_GM_PWM && c_hi < {16'h0, match[31:16]};
		end
	end
endmodule // mts_gtu

//--- tb/mts_timer_sva.sv
// Port-level assertions for the timer subsystem.
`timescale 1ns/1ps
module mts_timer_sva (
	// Clock and reset
	input wire core_clk,
	input wire rstn,
	// Stimulus seen
	input wire [1:0] power_mode,
	input wire dbg_halt,
	input wire rtc_en,
	input wire rtc_dbg_run,
	input wire radio_on,
	input wire wdt_irq_clr,
	input wire aon_dbg_pause,
	// Results seen
	input wire [69:0] rtc_value_q,
	input wire [31:0] radio_time_q,
	input wire [127:0] gpt_value,
	input wire [7:0] gpt_evt_out,
	input wire [7:0] gpt_pwm,
	input wire wdt_irq_q,
	input wire wdt_rst_q,
	input wire aon_rst_q
);
	wire [31:0] rtc_mid;
	assign rtc_mid = rtc_value_q[47:16];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	a_rtc_off_hold: assert property (!rtc_en |=> $stable(rtc_value_q))
		else $error("counter moved while disabled");
	a_rtc_shut_hold: assert property (power_mode == 2'h3 |=> $stable(rtc_value_q))
		else $error("counter moved in shutdown");
	a_rtc_halt_hold: assert property (dbg_halt && !rtc_dbg_run |=> $stable(rtc_value_q))
		else $error("counter moved under halt");
	a_gpt_freeze: assert property (power_mode[1] |=> $stable(gpt_value) && gpt_evt_out == 8'h00 && gpt_pwm == 8'h00)
		else $error("general timer active in low power");
	a_radio_resync: assert property ($changed(radio_on) |=> radio_time_q == $past(rtc_mid))
		else $error("radio timer not resynchronised");
	a_wdt_rst_cause: assert property (wdt_rst_q |-> $past(wdt_irq_q))
		else $error("watchdog reset without prior interrupt");
	a_wdt_rst_pulse: assert property (wdt_rst_q |=> !wdt_rst_q)
		else $error("watchdog reset longer than one cycle");
	a_wdt_irq_sticky: assert property (wdt_irq_q && !wdt_irq_clr |=> wdt_irq_q)
		else $error("watchdog interrupt dropped uncleared");
	a_aon_rst_pulse: assert property (aon_rst_q |=> !aon_rst_q)
		else $error("always-on reset longer than one cycle");
	a_wdt_halt_hold: assert property (dbg_halt |=> !wdt_rst_q)
		else $error("watchdog reset under debugger halt");
	a_aon_halt_pause: assert property (dbg_halt && aon_dbg_pause |=> !aon_rst_q)
		else $error("always-on reset while paused");
endmodule // mts_timer_sva
bind mts_timer_top mts_timer_sva u_sva (
	.core_clk(core_clk),
	.rstn(rstn),
	.power_mode(power_mode),
	.dbg_halt(dbg_halt),
	.rtc_en(rtc_en),
	.rtc_dbg_run(rtc_dbg_run),
	.radio_on(radio_on),
	.wdt_irq_clr(wdt_irq_clr),
	.aon_dbg_pause(aon_dbg_pause),
	.rtc_value_q(rtc_value_q),
	.radio_time_q(radio_time_q),
	.gpt_value(gpt_value),
	.gpt_evt_out(gpt_evt_out),
	.gpt_pwm(gpt_pwm),
	.wdt_irq_q(wdt_irq_q),
	.wdt_rst_q(wdt_rst_q),
	.aon_rst_q(aon_rst_q)
);

//--- tb/mts_evt_fabric.sv
// Event fabric model that feeds edge events to the general timers.
`timescale 1ns/1ps
module mts_evt_fabric (
	// Clock
	input wire clk,
	// Requests and events
	input wire [7:0] req,
	output reg [7:0] evt
);
	initial evt = 8'h00;
	// Each request becomes a one-cycle pulse unless a pulse was just sent, so a held request gives an edge every second cycle.
	always @(posedge clk) begin
		evt <= req & ~evt;
	end
endmodule // mts_evt_fabric

//--- tb/mts_timer_top_bench.sv
// Self-checking bench for the timer subsystem.
`timescale 1ns/1ps
`include "mts_defines.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
`define WAITF(c, n) begin wc = 0; while (!(c) && wc < (n)) begin @(negedge core_clk); wc++; end \
	if (!(c)) begin miscompares++; $display("[FAIL] %0t wait ran out", $time); final_report(); end end
module mts_timer_top_bench;
	reg core_clk, rstn, dbg_halt, rtc_en, rtc_dbg_run, rtc_cal_en, aux2_en, radio_on;
	reg wdt_start, wdt_kick, wdt_irq_clr, aon_start, aon_kick, aon_dbg_pause;
	reg [1:0] power_mode, rtc_cap_evt, aux_en, aux_periodic, aux_src_edge, aux_tick_in, aux2_clk_sel;
	reg [2:0] rtc_ch_en;
	reg [3:0] gpt_split, aux2_ch_en, aux2_ch_cap, aux2_ch_periodic, aux2_cap_in;
	reg [7:0] gpt_en, aux_pre, fab_req;
	reg [15:0] rtc_cal, aux2_period;
	reg [23:0] gpt_mode;
	reg [31:0] rtc_inc, rtc_cmp, aux_target, wdt_load, aon_timeout, r;
	reg [63:0] aux2_cmp;
	reg [127:0] gpt_load, gpt_match, gv;
	reg [69:0] p;
	wire [69:0] rtc_value_q;
	wire rtc_cmp_evt_q, wdt_irq_q, wdt_rst_q, aon_rst_q;
	wire [31:0] rtc_cap1_q, rtc_cap2_q, aux_value, radio_time_q;
	wire [127:0] gpt_value;
	wire [7:0] gpt_evt_in, gpt_evt_out, gpt_pwm;
	wire [1:0] aux_evt;
	wire [15:0] aux2_value_q;
	wire [63:0] aux2_ch_val;
	wire [3:0] aux2_evt, aux2_pwm;
	int checked, miscompares, wc;
	mts_timer_top uut (.*);
	mts_evt_fabric u_fab (.clk(core_clk), .req(fab_req), .evt(gpt_evt_in));
	always #4 core_clk = ~core_clk;
	task final_report;
		begin
			$display("checked=%0d miscompares=%0d", checked, miscompares);
			if (miscompares == 0 && checked > 0) $display("TEST PASSED");
			else $display("TEST FAILED");
			$finish;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// Returns on the negedge after the timer has seen the fabric edge.
	task fab_pulse(input [7:0] m);
		begin
			@(posedge core_clk);
			fab_req <= m;
			@(posedge core_clk);
			fab_req <= 8'h00;
			@(posedge core_clk);
			@(negedge core_clk);
		end
	endtask
	task aux_pulse;
		begin
			@(posedge core_clk);
			aux_tick_in <= 2'h1;
			@(posedge core_clk);
			aux_tick_in <= 2'h0;
			@(negedge core_clk);
		end
	endtask
	// Notes the counter value that the capture edge will see.
	task a2_cap;
		begin
			@(posedge core_clk);
			aux2_cap_in <= 4'h2;
			@(negedge core_clk);
			r = aux2_value_q;
			@(posedge core_clk);
			aux2_cap_in <= 4'h0;
			@(negedge core_clk);
		end
	endtask
	// Waits for the next counter step and checks its size.
	task rtc_step(input [69:0] d);
		begin
			@(negedge core_clk);
			p = rtc_value_q;
			`WAITF(rtc_value_q !== p, 5000)
			`CHK(rtc_value_q - p, d)
		end
	endtask
	task t_rtc;
		begin
			@(posedge core_clk);
			rtc_inc <= 32'h00800000;
			rtc_en <= 1'b1;
			`WAITF(rtc_value_q !== 70'h0, 5000)
			`CHK(rtc_value_q, 70'h00800000)
			@(posedge core_clk);
			rtc_cal_en <= 1'b1;
			rtc_cal <= 16'h0010;
			rtc_step(70'h00800010);
			@(posedge core_clk);
			radio_on <= 1'b1;
			cyc(3);
			`CHK(radio_time_q - rtc_value_q[47:16] < 32'h2, 1'b1)
			r = radio_time_q;
			cyc(200);
			`CHK((radio_time_q - r) inside {32'h6, 32'h7}, 1'b1)
			@(posedge core_clk);
			dbg_halt <= 1'b1;
			@(negedge core_clk);
			p = rtc_value_q;
			cyc(4000);
			`CHK(rtc_value_q, p)
			@(posedge core_clk);
			rtc_dbg_run <= 1'b1;
			rtc_step(70'h00800010);
			@(posedge core_clk);
			{dbg_halt, rtc_dbg_run} <= 2'h0;
			power_mode <= `MTS_PM_SHUTDOWN;
			@(negedge core_clk);
			p = rtc_value_q;
			cyc(4000);
			`CHK(rtc_value_q, p)
			@(posedge core_clk);
			power_mode <= `MTS_PM_IDLE;
			rtc_step(70'h00800010);
			@(posedge core_clk);
			rtc_ch_en <= 3'h7;
			rtc_cap_evt <= 2'h3;
			rtc_cmp <= rtc_value_q[`MTS_RTC_SL_HI:`MTS_RTC_SL_LO] + 32'h2;
			@(posedge core_clk);
			rtc_cap_evt <= 2'h0;
			@(negedge core_clk);
			`CHK({rtc_cap2_q, rtc_cap1_q}, {2{rtc_value_q[53:22]}})
			// One tick moves the slice by two, so the compare hits on the next tick.
			`WAITF(rtc_cmp_evt_q, 5000)
			`CHK(rtc_value_q[53:22], rtc_cmp)
		end
	endtask
	task t_gpt;
		begin
			@(posedge core_clk);
			power_mode <= `MTS_PM_ACTIVE;
			gpt_load <= {32'h9, 32'h0, 32'h3, 32'h5};
			gpt_mode <= 24'h0a3040;
			gpt_split <= 4'h4;
			gpt_match <= {32'h5, 32'h00020000, 64'h0};
			gpt_en <= 8'h75;
			`WAITF(gpt_evt_out[0], 100)
			`CHK(gpt_value[31:0], 32'h0)
			cyc(20);
			`CHK(gpt_value[31:0], 32'h0)
			`WAITF(gpt_evt_out[2], 100)
			`CHK(gpt_value[63:32], 32'h3)
			`WAITF(!gpt_pwm[6], 40)
			`WAITF(gpt_pwm[6], 40)
			`CHK(gpt_value[127:96] inside {32'h3, 32'h4}, 1'b1)
			// A gap of 123 puts 125 core cycles between the two sampled edges.
			fab_pulse(8'h10);
			cyc(123);
			fab_pulse(8'h10);
			`CHK(gpt_evt_out[4], 1'b1)
			`CHK(gpt_value[79:64] inside {16'h2f, 16'h30}, 1'b1)
			fab_pulse(8'h20);
			`CHK(gpt_value[95:80], 16'h1)
			fab_pulse(8'h20);
			`CHK(gpt_value[95:80], 16'h2)
			`CHK(gpt_evt_out[5], 1'b1)
			@(posedge core_clk);
			power_mode <= `MTS_PM_STANDBY;
			@(negedge core_clk);
			gv = gpt_value;
			cyc(30);
			`CHK(gpt_value, gv)
		end
	endtask
	task t_aux;
		begin
			@(posedge core_clk);
			aux_src_edge <= 2'h1;
			aux_pre <= 8'h01;
			aux_target <= {16'h3, 16'h2};
			aux_periodic <= 2'h2;
			aux_en <= 2'h3;
			`WAITF(aux_evt[1], 100)
			`CHK(aux_value[31:16], 16'h0)
			cyc(1);
			`WAITF(aux_evt[1], 40)
			`CHK(aux_value[31:16], 16'h0)
			repeat (4) aux_pulse();
			`CHK(aux_value[15:0], 16'h2)
			repeat (2) aux_pulse();
			`CHK(aux_evt[0], 1'b1)
			repeat (2) aux_pulse();
			`CHK(aux_value[15:0], 16'h0)
		end
	endtask
	task t_aux2;
		begin
			@(posedge core_clk);
			aux2_clk_sel <= `MTS_A2_SEL_2M;
			aux2_period <= 16'hffff;
			aux2_en <= 1'b1;
			@(negedge core_clk);
			r = aux2_value_q;
			cyc(250);
			`CHK((aux2_value_q - r) inside {32'h3, 32'h4}, 1'b1)
			@(posedge core_clk);
			aux2_clk_sel <= `MTS_A2_SEL_24M;
			aux2_period <= 16'h9;
			aux2_cmp <= 64'h4;
			aux2_ch_cap <= 4'h2;
			aux2_ch_periodic <= 4'h1;
			aux2_ch_en <= 4'h3;
			`WAITF(aux2_evt[0], 100)
			`CHK(aux2_value_q, 16'h5)
			`CHK(aux2_pwm[0], 1'b0)
			`WAITF(aux2_pwm[0], 100)
			`CHK(aux2_value_q < 16'h5, 1'b1)
			`WAITF(aux2_evt[0], 100)
			`CHK(aux2_value_q, 16'h5)
			a2_cap();
			`CHK(aux2_ch_val[31:16], r[15:0])
			`CHK(aux2_evt[1], 1'b1)
			a2_cap();
			`CHK(aux2_evt[1], 1'b0)
		end
	endtask
	task t_wdt;
		begin
			@(posedge core_clk);
			wdt_load <= 32'h3;
			wdt_start <= 1'b1;
			@(posedge core_clk);
			wdt_start <= 1'b0;
			`WAITF(wdt_irq_q, 1000)
			`CHK(wdt_rst_q, 1'b0)
			`WAITF(wdt_rst_q, 1000)
			`CHK(wdt_irq_q, 1'b1)
			@(posedge core_clk);
			wdt_irq_clr <= 1'b1;
			@(posedge core_clk);
			wdt_irq_clr <= 1'b0;
			@(negedge core_clk);
			`CHK(wdt_irq_q, 1'b0)
			// Holding kick reloads every cycle, so the count never reaches zero.
			@(posedge core_clk);
			wdt_kick <= 1'b1;
			cyc(500);
			`CHK(wdt_irq_q, 1'b0)
			@(posedge core_clk);
			wdt_kick <= 1'b0;
			// Still counting in standby although start is long gone.
			`WAITF(wdt_irq_q, 1000)
			`CHK(wdt_irq_q, 1'b1)
		end
	endtask
	task t_aon;
		begin
			@(posedge core_clk);
			aon_timeout <= 32'h1;
			aon_start <= 1'b1;
			@(posedge core_clk);
			aon_start <= 1'b0;
			`WAITF(aon_rst_q, 8000)
			`CHK(aon_rst_q, 1'b1)
			@(posedge core_clk);
			dbg_halt <= 1'b1;
			cyc(2);
			`WAITF(aon_rst_q, 8000)
			`CHK(aon_rst_q, 1'b1)
			@(posedge core_clk);
			aon_dbg_pause <= 1'b1;
			cyc(4000);
			`CHK(aon_rst_q, 1'b0)
		end
	endtask
	initial begin
		{core_clk, rstn, dbg_halt, rtc_en, rtc_dbg_run, rtc_cal_en, aux2_en, radio_on} = '0;
		{wdt_start, wdt_kick, wdt_irq_clr, aon_start, aon_kick, aon_dbg_pause} = '0;
		{power_mode, rtc_cap_evt, aux_en, aux_periodic, aux_src_edge, aux_tick_in} = '0;
		{aux2_clk_sel, rtc_ch_en, gpt_split, aux2_ch_en, aux2_ch_cap, aux2_ch_periodic} = '0;
		{aux2_cap_in, gpt_en, aux_pre, fab_req, rtc_cal, aux2_period, gpt_mode} = '0;
		{rtc_inc, rtc_cmp, aux_target, wdt_load, aon_timeout, aux2_cmp, gpt_load, gpt_match} = '0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		cyc(3);
		`CHK({rtc_value_q, radio_time_q, wdt_irq_q, aon_rst_q}, 104'h0)
		`CHK(gpt_value, 128'h0)
		t_rtc();
		t_gpt();
		t_aux();
		t_aux2();
		t_wdt();
		t_aon();
		final_report();
	end
endmodule // mts_timer_top_bench
